// File: core/echo_canceller_adapt_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ec_ctrl_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Halt adaptation while double-talk exceeds threshold
// - Uncertain talk slows adaptation; zero halts
// - Double-talk threshold 16 bits, default 0x4800
// - Path detector enabled triggers fast reconvergence
// - Path clear zeroes coefficients on change
// - Residual below threshold gets extra attenuation
// - Suppression threshold 16-bit fraction times 32768
// - Inject comfort noise while attenuating
// - Disable bit turns residual suppression off
// - Noise disable; injection only when suppressor on
// - Ramp select and increment set ramp speed
// - Noise scale register scales noise amplitude
// - Two guard bits protect noise estimate
// - Phase mode: one second plus reversal
// - Plain mode: tone for 400 ms
// - Two detectors; status high, interrupt low
// - Status held until quiet 400 ms; interrupt
// - Phase-disable bit selects plain criteria
// - Auto bit moves channel to bypass
// - Instability enable bit suppresses ringing
// - Narrowband tones halt adaptation; disable bit
// - Bypass passes through, zeroes coefficients
module echo_canceller_adapt_control #(
    parameter logic [`CNT_W-1:0] TONE_PLAIN_CYC = `CNT_W'(`MS_CYC(`TONE_PLAIN_MS)),
    parameter logic [`CNT_W-1:0] TONE_PHASE_CYC = `CNT_W'(`MS_CYC(`TONE_PHASE_MS)),
    parameter logic [`CNT_W-1:0] TONE_REL_CYC   = `CNT_W'(`MS_CYC(`TONE_REL_MS))
) (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire ec_ctrl_pkg::meas_t   meas,
    input  wire ec_ctrl_pkg::tone_in_t tone_rx,
    input  wire ec_ctrl_pkg::tone_in_t tone_tx,
    output ec_ctrl_pkg::dp_ctrl_t     dp_ctrl,
    output logic                      tone_irq_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and internal state
    // Map, one aligned word each:
    //   control     mode bits and slow field
    //   dtt         double-talk fraction
    //   supt        suppression fraction
    //   nscale      comfort noise gain
    //   rinc        ramp step or shift
    //   status      read only; read clears pending
    logic [31:0]              ctrl_r;
    logic [15:0]              dtt_r;
    logic [15:0]              supt_r;
    logic [15:0]              nscale_r;
    logic [15:0]              rinc_r;
    logic [31:0]              prdata_r;
    logic                     pready_r;
    logic                     pslverr_r;
    logic                     irq_pend_r;
    logic [15:0]              bg_r;
    ec_ctrl_pkg::dp_ctrl_t    dp_r;
    ec_ctrl_pkg::td_state_t   td_state_r;
    logic [`CNT_W-1:0]        rel_cnt_r;
    logic [1:0]               trig;
    logic                     auto_byp_r;
    logic                     wr_done;
    logic                     rd_status_done;
    logic                     mapped;
    logic [31:0]              rd_mux;

    // Control fields
    // Bits above the slow field are stored as zero
    logic       byp_host;
    logic       adapt_dis;
    logic [3:0] slow;

    assign byp_host  = ctrl_r[`B_BYPASS];
    assign adapt_dis = ctrl_r[`B_ADAPT_DIS];
    assign slow      = ctrl_r[`B_SLOW_HI:`B_SLOW_LO];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then pready for a single cycle
    // The fixed wait keeps read data registered, so
    // the read mux never sits on the prdata path.
    assign wr_done = psel && penable && pready_r && pwrite;
    assign rd_status_done = psel && penable && pready_r && !pwrite
                            && (paddr == `OFS_STATUS);

    // Address decode and read mux
    // Unmapped offsets read zero and raise pslverr
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `OFS_CTRL:   rd_mux = ctrl_r;
            `OFS_DTT:    rd_mux = {16'h0000, dtt_r};
            `OFS_SUPT:   rd_mux = {16'h0000, supt_r};
            `OFS_NSCALE: rd_mux = {16'h0000, nscale_r};
            `OFS_RINC:   rd_mux = {16'h0000, rinc_r};
            `OFS_STATUS: rd_mux = {29'h0000_0000, auto_byp_r, irq_pend_r,
                                   td_state_r == ec_ctrl_pkg::TD_HELD};
            default:     mapped = 1'b0;
        endcase
    end

    // Handshake and captured read data
    // pready drops after one cycle; a request still
    // held is answered again every second cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (psel && penable && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Software-written registers, updated at the completing edge
    // Unmapped and status writes are dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r   <= `CTRL_RST;
            dtt_r    <= `DTT_RST;
            supt_r   <= `SUPT_RST;
            nscale_r <= `NSCALE_RST;
            rinc_r   <= `RINC_RST;
        end else if (wr_done) begin
            unique case (paddr)
                `OFS_CTRL:   ctrl_r   <= {15'h0000, pwdata[`B_SLOW_HI:0]};
                `OFS_DTT:    dtt_r    <= pwdata[15:0];
                `OFS_SUPT:   supt_r   <= pwdata[15:0];
                `OFS_NSCALE: nscale_r <= pwdata[15:0];
                `OFS_RINC:   rinc_r   <= pwdata[15:0];
                default:     ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level comparisons in linear form: a > b * thr / 32768
    // The dB relation becomes a product of levels;
    // the shift matches the fraction scale, and
    // the 32-bit products cannot overflow.
    logic [31:0] lsin_sc;
    logic [31:0] dt_lim;
    logic [31:0] res_sc;
    logic [31:0] sup_lim;
    logic        dbl_talk;
    logic        below_sup;

    assign lsin_sc = {1'b0, meas.lsin, 15'h0000};
    assign dt_lim  = meas.lrin * dtt_r;
    assign res_sc  = {1'b0, meas.resid, 15'h0000};
    assign sup_lim = meas.lrin * supt_r;
    assign dbl_talk  = lsin_sc > dt_lim;
    assign below_sup = res_sc < sup_lim;

    ////////////////////////////////////////////////////////////////////////////
    // Disable tone detectors, one per direction
    // Receive and send share one status bit
    ec_ctrl_pkg::tone_in_t td_in [2];
    assign td_in[0] = tone_rx;
    assign td_in[1] = tone_tx;

    for (genvar g = 0; g < 2; g++) begin : g_tone
        logic [`CNT_W-1:0] cnt_r;
        logic              rev_r;
        logic              met;

        assign met = ctrl_r[`B_PHASE_DIS] ? (cnt_r >= TONE_PLAIN_CYC)
                                          : (cnt_r >= TONE_PHASE_CYC) && rev_r;
        assign trig[g] = met && td_in[g].tone;

        // Tone duration and reversal tracking
        // The count saturates, so a long tone keeps met;
        // a gap restarts both count and reversal.
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                cnt_r <= `CNT_W'h0;
                rev_r <= 1'b0;
            end else if (!td_in[g].tone) begin
                cnt_r <= `CNT_W'h0;
                rev_r <= 1'b0;
            end else begin
                if (cnt_r != {`CNT_W{1'b1}}) begin
                    cnt_r <= cnt_r + `CNT_W'h1;
                end
                if (td_in[g].rev) begin
                    rev_r <= 1'b1;
                end
            end
        end
    end

    // Tone status: hold until both inputs quiet long enough
    // Noise on either input restarts the release count;
    // no fresh tone is needed to keep the status.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            td_state_r <= ec_ctrl_pkg::TD_IDLE;
            rel_cnt_r  <= `CNT_W'h0;
        end else begin
            unique case (td_state_r)
                ec_ctrl_pkg::TD_IDLE: begin
                    rel_cnt_r <= `CNT_W'h0;
                    if (|trig) begin
                        td_state_r <= ec_ctrl_pkg::TD_HELD;
                    end
                end
                ec_ctrl_pkg::TD_HELD: begin
                    // quiet on both inputs for the release time
                    if (!(tone_rx.quiet && tone_tx.quiet)) begin
                        rel_cnt_r <= `CNT_W'h0;
                    end else if (rel_cnt_r >= TONE_REL_CYC - `CNT_W'h1) begin
                        rel_cnt_r  <= `CNT_W'h0;
                        td_state_r <= ec_ctrl_pkg::TD_IDLE;
                    end else begin
                        rel_cnt_r <= rel_cnt_r + `CNT_W'h1;
                    end
                end
                default: td_state_r <= ec_ctrl_pkg::TD_IDLE;
            endcase
        end
    end

    // Interrupt on detect and release; status read clears, set wins
    // An event at the completing edge of a status read keeps the flag;
    // one at its wait edge is cleared without showing in the read data.
    logic td_edge;
    assign td_edge = (td_state_r == ec_ctrl_pkg::TD_IDLE && |trig)
                  || (td_state_r == ec_ctrl_pkg::TD_HELD && rel_cnt_r >= TONE_REL_CYC - `CNT_W'h1
                      && tone_rx.quiet && tone_tx.quiet);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_pend_r <= 1'b0;
            tone_irq_n <= 1'b1;
        end else begin
            if (td_edge) begin
                irq_pend_r <= 1'b1;
                tone_irq_n <= 1'b0;
            end else if (rd_status_done) begin
                irq_pend_r <= 1'b0;
                tone_irq_n <= 1'b1;
            end
        end
    end

    // Automatic bypass while the tone status is held
    // Only a channel in enable adaptation moves;
    // host bypass and adaptation disable stay put.
    // Release returns the channel to adaptation.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            auto_byp_r <= 1'b0;
        end else if (td_state_r != ec_ctrl_pkg::TD_HELD) begin
            auto_byp_r <= 1'b0;
        end else if (ctrl_r[`B_AUTO_TONE] && !byp_host && !adapt_dis) begin
            auto_byp_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Background noise estimate with ramping
    // Moves once per sample toward the measured
    // noise; the step never passes the target,
    // so the estimate cannot oscillate.
    logic noise_ok;
    logic [15:0] bg_diff;
    logic [15:0] bg_step;

    // guards keep talk and echo out of the estimate
    assign noise_ok = !(ctrl_r[`B_GUARD1] && dbl_talk)
                   && !(ctrl_r[`B_GUARD2] && meas.echo_left);
    assign bg_diff = (meas.noise > bg_r) ? meas.noise - bg_r : bg_r - meas.noise;
    assign bg_step = ctrl_r[`B_RAMP_SEL] ? (bg_diff >> rinc_r[3:0])
                   : ((bg_diff < rinc_r) ? bg_diff : rinc_r);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bg_r <= 16'h0000;
        end else if (meas.tick && noise_ok) begin
            bg_r <= (meas.noise > bg_r) ? bg_r + bg_step : bg_r - bg_step;
        end
    end

    // Noise amplitude: estimate times scale fraction
    logic [31:0] amp_full;
    assign amp_full = bg_r * nscale_r;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath control, registered
    // Halt freezes the coefficients; cancellation
    // keeps running with the last values.
    logic bypass_now;
    logic halt;

    assign bypass_now = byp_host || auto_byp_r;
    // any halting condition wins over slow rate
    assign halt = bypass_now || adapt_dis || dbl_talk
               || (meas.narrowband && !ctrl_r[`B_NB_DIS])
               || (meas.uncertain && slow == 4'h0);

    // One flop stage: controls follow causes a clock later
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dp_r <= '0;
        end else begin
            dp_r.adapt_en    <= !halt;
            // rate divided by two to the slow field
            dp_r.adapt_shift <= (meas.uncertain && !halt) ? slow : 4'h0;
            // fast reconvergence on a path change
            dp_r.fast_reconv <= ctrl_r[`B_PATH_EN] && meas.path_chg;
            // clear on path change; clear in bypass
            dp_r.coef_clear  <= bypass_now
                             || (ctrl_r[`B_PATH_EN] && ctrl_r[`B_PATH_CLR] && meas.path_chg);
            dp_r.pass_through <= bypass_now;
            dp_r.extra_atten <= !ctrl_r[`B_SUPP_DIS] && below_sup && !bypass_now;
            dp_r.noise_inject <= !ctrl_r[`B_SUPP_DIS] && below_sup && !bypass_now
                              && !ctrl_r[`B_CN_DIS];
            // amplitude scaled by the noise scale
            dp_r.noise_amp <= amp_full[`FRAC_SHIFT +: 16];
            dp_r.ring_suppress <= ctrl_r[`B_INSTAB_EN] && meas.ringing;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Every output is a flip-flop, no logic after it
    assign dp_ctrl = dp_r;
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

endmodule
`default_nettype wire

// File: core/ec_ctrl_cfg.svh
`ifndef EC_CTRL_CFG_SVH
`define EC_CTRL_CFG_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_DTT         8'h04
`define OFS_SUPT        8'h08
`define OFS_NSCALE      8'h0c
`define OFS_RINC        8'h10
`define OFS_STATUS      8'h14

// Control register field positions
`define B_BYPASS        0
`define B_ADAPT_DIS     1
`define B_PATH_EN       2
`define B_PATH_CLR      3
`define B_SUPP_DIS      4
`define B_CN_DIS        5
`define B_RAMP_SEL      6
`define B_GUARD1        7
`define B_GUARD2        8
`define B_PHASE_DIS     9
`define B_AUTO_TONE     10
`define B_INSTAB_EN     11
`define B_NB_DIS        12
`define B_SLOW_LO       13
`define B_SLOW_HI       16

// Reset values
`define CTRL_RST        32'h0000_8180
`define DTT_RST         16'h4800
`define SUPT_RST        16'h1000
`define NSCALE_RST      16'h4000
`define RINC_RST        16'h0004

// Fractional scaling: thresholds hold value times 32768
`define FRAC_SHIFT      15

// Timing
`define CLK_HZ          10000000
`define TONE_PLAIN_MS   400
`define TONE_PHASE_MS   1000
`define TONE_REL_MS     400
`define MS_CYC(ms)      ((ms) * (`CLK_HZ / 1000))
`define CNT_W           24

`endif

// File: core/ec_ctrl_pkg.sv
`default_nettype none
package ec_ctrl_pkg;

    // Per-sample measurements from the filter datapath
    typedef struct packed {
        logic        tick;        // One pulse per 8 kHz sample
        logic [15:0] lsin;        // Send-input level, linear
        logic [15:0] lrin;        // Receive-input level, linear
        logic [15:0] resid;       // Residual error level, linear
        logic [15:0] noise;       // Background noise level measured
        logic        uncertain;   // Weak double-talk or echo undecided
        logic        echo_left;   // Uncancelled echo seen
        logic        path_chg;    // Major echo path change seen
        logic        narrowband;  // Single or dual tone on receive input
        logic        ringing;     // Oscillation seen
    } meas_t;

    // Per-direction disable tone measurements
    typedef struct packed {
        logic tone;               // 2100 Hz present
        logic rev;                // Phase reversal pulse
        logic quiet;              // Below release levels in both bands
    } tone_in_t;

    // Control toward the filter datapath
    typedef struct packed {
        logic        adapt_en;
        logic [3:0]  adapt_shift;
        logic        fast_reconv;
        logic        coef_clear;
        logic        pass_through;
        logic        extra_atten;
        logic        noise_inject;
        logic [15:0] noise_amp;
        logic        ring_suppress;
    } dp_ctrl_t;

    typedef enum logic [1:0] {
        TD_IDLE = 2'b00,
        TD_HELD = 2'b01
    } td_state_t;

endpackage
`default_nettype wire

// File: dv/ec_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ec_ctrl_cfg.svh"
module ec_ctrl_checker (
    input wire logic                  sys_clk,
    input wire logic                  nrst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire ec_ctrl_pkg::meas_t    meas,
    input wire ec_ctrl_pkg::dp_ctrl_t dp_ctrl,
    input wire logic                  tone_irq_n
);
    logic [31:0] ctrl_r;
    logic [15:0] dtt_r;
    logic        done;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Completed bus transfer
    assign done = psel && penable && pready;
    // Shadow of the control word and the double-talk threshold
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `CTRL_RST;
            dtt_r  <= `DTT_RST;
        end else if (done && pwrite && paddr == `OFS_CTRL) begin
            ctrl_r <= pwdata;
        end else if (done && pwrite && paddr == `OFS_DTT) begin
            dtt_r <= pwdata[15:0];
        end
    end
    ////////////////////////////////////////
    chk_talk_halts: assert property ({1'b0, meas.lsin, 15'h0000} > meas.lrin * dtt_r
        |=> !dp_ctrl.adapt_en)
        else $error("adaptation during double talk");
    chk_slow_zero: assert property (meas.uncertain && ctrl_r[16:13] == 4'h0 |=> !dp_ctrl.adapt_en)
        else $error("zero slow field did not halt");
    chk_slow_shift: assert property ($past(meas.uncertain) && dp_ctrl.adapt_en
        |-> dp_ctrl.adapt_shift == $past(ctrl_r[16:13]))
        else $error("slowed rate shift wrong");
    chk_nb_halts: assert property (meas.narrowband && !ctrl_r[`B_NB_DIS] |=> !dp_ctrl.adapt_en)
        else $error("adaptation during narrow band tone");
    chk_bypass_pass: assert property (ctrl_r[`B_BYPASS] |=> dp_ctrl.pass_through && dp_ctrl.coef_clear)
        else $error("bypass not applied");
    chk_path_fast: assert property (meas.path_chg && ctrl_r[`B_PATH_EN] && !ctrl_r[`B_BYPASS]
        |=> dp_ctrl.fast_reconv)
        else $error("no fast reconvergence");
    chk_path_clear: assert property (meas.path_chg && ctrl_r[`B_PATH_EN] && ctrl_r[`B_PATH_CLR]
        |=> dp_ctrl.coef_clear)
        else $error("no clear on path change");
    chk_supp_off: assert property (ctrl_r[`B_SUPP_DIS] |=> !dp_ctrl.extra_atten && !dp_ctrl.noise_inject)
        else $error("suppression while disabled");
    chk_noise_off: assert property (ctrl_r[`B_CN_DIS] |=> !dp_ctrl.noise_inject)
        else $error("noise while disabled");
    chk_noise_with: assert property (dp_ctrl.extra_atten && !$past(ctrl_r[`B_CN_DIS]) |-> dp_ctrl.noise_inject)
        else $error("attenuation without comfort noise");
    chk_ring_off: assert property (meas.ringing && !ctrl_r[`B_INSTAB_EN] |=> !dp_ctrl.ring_suppress)
        else $error("ringing suppressed while disabled");
    chk_irq_held: assert property (!tone_irq_n && !(done && !pwrite && paddr == `OFS_STATUS)
        |=> !tone_irq_n)
        else $error("interrupt dropped before status read");
    cov_irq: cover property ($fell(tone_irq_n));
    cov_bypass: cover property (dp_ctrl.pass_through);
    cov_atten: cover property (dp_ctrl.extra_atten && dp_ctrl.noise_inject);
endmodule
bind echo_canceller_adapt_control ec_ctrl_checker chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .meas(meas),
    .dp_ctrl(dp_ctrl), .tone_irq_n(tone_irq_n));
`default_nettype wire

// File: dv/meas_source.sv
`timescale 1ns/1ps
`default_nettype none
module meas_source #(
    parameter int TICK_DIV = 8
) (
    input  wire logic              sys_clk,
    output ec_ctrl_pkg::meas_t     meas,
    output ec_ctrl_pkg::tone_in_t  tone_rx,
    output ec_ctrl_pkg::tone_in_t  tone_tx
);
    int cnt = 0;
    // Levels start quiet; the bench sets them between samples
    initial begin
        meas = '0;
        tone_rx = 3'b001;
        tone_tx = 3'b001;
    end
    // One sample pulse per frame
    always @(posedge sys_clk) begin
        cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
        meas.tick <= (cnt == 0);
    end
endmodule
`default_nettype wire

// File: dv/test_echo_canceller_adapt_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ec_ctrl_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module test_echo_canceller_adapt_control;
    logic                  sys_clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           rd;
    logic                  er;
    int                    fails = 0;
    int                    comparisons = 0;
    int                    n;
    ec_ctrl_pkg::meas_t    meas;
    ec_ctrl_pkg::tone_in_t tone_rx;
    ec_ctrl_pkg::tone_in_t tone_tx;
    ec_ctrl_pkg::dp_ctrl_t dp_ctrl;
    logic                  tone_irq_n;

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    echo_canceller_adapt_control #(.TONE_PLAIN_CYC(24'h14), .TONE_PHASE_CYC(24'h32), .TONE_REL_CYC(24'h14)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
        .tone_rx(tone_rx), .tone_tx(tone_tx), .dp_ctrl(dp_ctrl), .tone_irq_n(tone_irq_n));
    meas_source src (.sys_clk(sys_clk), .meas(meas), .tone_rx(tone_rx), .tone_tx(tone_tx));

    ////////////////////////////////////////
    // One bus transfer, released after the answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // Cycles until the interrupt line goes low
    task automatic wirq();
        n = 0;
        while (tone_irq_n !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(tone_irq_n, 1'b0)
    endtask
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Watchdog
    initial begin
        #2000000;
        fails++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rchk(`OFS_CTRL, `CTRL_RST);
        rchk(`OFS_DTT, 32'h0000_4800);
        rchk(`OFS_SUPT, 32'h0000_1000);
        rchk(`OFS_NSCALE, 32'h0000_4000);
        rchk(`OFS_RINC, 32'h0000_0004);
        apb(1'b0, 8'h18, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        apb(1'b1, `OFS_DTT, 32'h0000_4000);
        rchk(`OFS_DTT, 32'h0000_4000);
        src.meas.lrin <= 16'h1000;
        src.meas.lsin <= 16'h0801;
        step(2);
        `CHK(dp_ctrl.adapt_en, 1'b0)
        src.meas.lsin <= 16'h0800;
        step(2);
        `CHK(dp_ctrl.adapt_en, 1'b1)
        src.meas.uncertain <= 1'b1;
        step(2);
        `CHK({dp_ctrl.adapt_en, dp_ctrl.adapt_shift}, 5'h14)
        apb(1'b1, `OFS_CTRL, 32'h0000_0180);
        step(2);
        `CHK(dp_ctrl.adapt_en, 1'b0)
        src.meas.uncertain <= 1'b0;
        src.meas.narrowband <= 1'b1;
        apb(1'b1, `OFS_CTRL, 32'h0000_8180);
        step(2);
        `CHK(dp_ctrl.adapt_en, 1'b0)
        apb(1'b1, `OFS_CTRL, 32'h0000_9180);
        step(2);
        `CHK(dp_ctrl.adapt_en, 1'b1)
        src.meas.narrowband <= 1'b0;
        src.meas.resid <= 16'h01ff;
        step(2);
        `CHK({dp_ctrl.extra_atten, dp_ctrl.noise_inject}, 2'b11)
        src.meas.resid <= 16'h0200;
        step(2);
        `CHK(dp_ctrl.extra_atten, 1'b0)
        src.meas.resid <= 16'h01ff;
        apb(1'b1, `OFS_CTRL, 32'h0000_81a0);
        step(2);
        `CHK({dp_ctrl.extra_atten, dp_ctrl.noise_inject}, 2'b10)
        apb(1'b1, `OFS_CTRL, 32'h0000_8190);
        step(2);
        `CHK({dp_ctrl.extra_atten, dp_ctrl.noise_inject}, 2'b00)
        src.meas.path_chg <= 1'b1;
        apb(1'b1, `OFS_CTRL, 32'h0000_818c);
        step(2);
        `CHK({dp_ctrl.fast_reconv, dp_ctrl.coef_clear}, 2'b11)
        apb(1'b1, `OFS_CTRL, 32'h0000_8180);
        step(2);
        `CHK(dp_ctrl.fast_reconv, 1'b0)
        src.meas.path_chg <= 1'b0;
        src.meas.ringing <= 1'b1;
        step(2);
        `CHK(dp_ctrl.ring_suppress, 1'b0)
        apb(1'b1, `OFS_CTRL, 32'h0000_8980);
        step(2);
        `CHK(dp_ctrl.ring_suppress, 1'b1)
        src.meas.ringing <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h0000_8380);
        src.tone_rx <= 3'b100;
        src.tone_tx <= 3'b000;
        wirq();
        `CHK(n >= 19 && n <= 25, 1'b1)
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK({rd[0], tone_irq_n}, 2'b11)
        apb(1'b1, `OFS_CTRL, 32'h0000_8381);
        step(2);
        `CHK(dp_ctrl.pass_through, 1'b1)
        apb(1'b1, `OFS_CTRL, 32'h0000_8380);
        src.tone_rx <= 3'b000;
        step(30);
        rchk(`OFS_STATUS, 32'h0000_0001);
        src.tone_rx <= 3'b001;
        src.tone_tx <= 3'b001;
        wirq();
        `CHK(n >= 19 && n <= 25, 1'b1)
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[0], 1'b0)
        apb(1'b1, `OFS_CTRL, 32'h0000_8180);
        src.tone_rx <= 3'b100;
        src.tone_tx <= 3'b000;
        step(60);
        `CHK(tone_irq_n, 1'b1)
        src.tone_rx <= 3'b110;
        step(1);
        src.tone_rx <= 3'b100;
        wirq();
        `CHK(n <= 4, 1'b1)
        apb(1'b0, `OFS_STATUS, 32'h0);
        src.tone_rx <= 3'b001;
        src.tone_tx <= 3'b001;
        wirq();
        apb(1'b1, `OFS_CTRL, 32'h0000_8780);
        apb(1'b0, `OFS_STATUS, 32'h0);
        src.tone_rx <= 3'b000;
        src.tone_tx <= 3'b100;
        wirq();
        step(2);
        `CHK(dp_ctrl.pass_through, 1'b1)
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[2], 1'b1)
        src.tone_rx <= 3'b001;
        src.tone_tx <= 3'b001;
        wirq();
        step(2);
        `CHK(dp_ctrl.pass_through, 1'b0)
        src.meas.noise <= 16'h0010;
        step(60);
        `CHK(dp_ctrl.noise_amp, 16'h0008)
        src.meas.echo_left <= 1'b1;
        src.meas.noise <= 16'h0100;
        step(60);
        `CHK(dp_ctrl.noise_amp, 16'h0008)
        final_report();
    end
endmodule
`default_nettype wire
